// *** src/hbsc_top.sv ***
// Behaviour
// - Commands decode on upper three bits; low five are data or ignored.
// - Read-revision, read-fault and read-control return the named byte.
// - Write-control loads five data bits and returns the control register.
// - Write-control-read-fault loads five data bits, returns the fault register.
// - Clear-fault clears latched faults and returns the fault register.
// - First response after power-up is the revision byte.
// - Unknown command codes return the fault register.
// - Control bits 7:5 hold the last control command code; reset zero.
// - Open-load source off disconnects the source and hides open load.
// - Serial control select picks pins (0) or register bits (1).
// - Select bit sets only while disable, modulation, direction pins low.
// - Any change on those three pins clears the select bit.
// - Under serial control, enable bit replaces the disable pin.
// - Under serial control, register bits give direction and modulation.
// - Fault bit 7 shows outputs enabled by low disable pin; reset DF.
// - Bit 6 low in overtemperature, bit 4 low from current limit until cleared.
// - Fault bit 5 always reads zero.
// - Fault code bits 3:0 encode shorts, open load and undervoltage.
// - Only listed codes; shorts latch, open load and undervoltage live.
// - Fault latches clear on reset, undervoltage and leaving sleep.
// - Fault latches clear on re-enable by pin or serial enable bit.
// - Direction change clears current limit and open load in on state.
// - Open load in on clears after five freewheeling pulses in a row.
// - Frames are eight bits MSB first under chip select; no count check.
// - Input sampled on falling clock edge, output changes on rising edge.
// - Bridge follows the output truth table, disabled means all off.
// - Open load in on reported after five pulses without freewheeling.
`timescale 1ns/1ps
`include "hbsc_consts.svh"

// ----------------------------------------
// Serial link, runs on the serial clock
// ----------------------------------------
module hbsc_link
	import hbsc_pkg::*;
(
	input wire logic sclk,
	input wire logic csn,
	input wire logic si,
	input wire logic [7:0] respByte,
	output logic [7:0] rxByte,
	output logic so,
	output logic soOe
);
	logic [7:0] rxReg;
	logic [7:0] rxNext;
	hbsc_tx_t txReg;
	hbsc_tx_t txNext;

	always_comb begin
		// MSB first shift, no count check
		rxNext = 8'({rxReg, si});
		txNext.idx = txReg.idx + 3'h1;
		txNext.bitOut = respByte[~txReg.idx];
	end

	always_ff @(negedge sclk) begin
		rxReg <= rxNext;
	end

	// Drive on rising edge; chip select high ends the frame
	always_ff @(posedge sclk or posedge csn) begin
		if (csn) begin
			txReg <= '0;
		end else begin
			txReg <= txNext;
		end
	end

	assign rxByte = rxReg;
	assign so = txReg.bitOut;
	assign soOe = !csn;
endmodule : hbsc_link

// ----------------------------------------
// Short latch gate for one output
// ----------------------------------------
module hbsc_short_side
	import hbsc_pkg::*;
(
	input wire logic groundLatched,
	input wire logic batteryLatched,
	input wire logic clear,
	input wire logic groundNow,
	input wire logic batteryNow,
	output logic groundSet,
	output logic batterySet
);
	logic sideFree;

	// Only one short per output latches, so double codes stay in the listed set
	// A clear in the same cycle frees the side, so a live short wins over it
	assign sideFree = clear || !(groundLatched || batteryLatched);
	// Ground wins when both shorts arrive together
	assign groundSet = sideFree && groundNow;
	assign batterySet = sideFree && batteryNow && !groundNow;
endmodule : hbsc_short_side

// ----------------------------------------
// Command interpreter and registers
// ----------------------------------------
module hbsc_top
	import hbsc_pkg::*;
#(
	parameter int OL_PULSES = `HBSC_OPEN_LOAD_PULSES,
	// Arbitrary revision value
	parameter logic [3:0] REVISION = 4'h1
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic csn,
	input wire logic si,
	output logic so,
	output logic soOe,
	input wire hbsc_pins_t pins,
	output hbsc_bridge_t bridge,
	output logic openLoadSourceOn
);
	if (OL_PULSES < 1 || OL_PULSES > 7) begin : gChk
		$error("OL_PULSES must lie in 1..7");
	end

	localparam logic [2:0] OL_LIMIT = 3'(OL_PULSES);
	localparam logic [7:0] REV_BYTE = {`HBSC_REVISION_HIGH, REVISION};

	hbsc_core_t r;
	hbsc_core_t n;
	logic [7:0] rxByte;
	hbsc_ctrl_t cmdByte;
	hbsc_pins_t pin;
	hbsc_fault_t fault;
	logic frameEnd;
	logic [2:0] pinsNow;
	logic pinChange;
	logic effEn;
	logic effDir;
	logic effMod;
	logic dirChange;
	logic modFall;
	logic isWrite;
	logic isClear;
	logic faultClear;
	logic stop;
	logic olReport;
	hbsc_shorts_t shortSet;
	logic setGroundA;
	logic setBatteryA;
	logic setGroundB;
	logic setBatteryB;

	hbsc_link uLink (
		.sclk(sclk),
		.csn(csn),
		.si(si),
		.respByte(r.resp),
		.rxByte(rxByte),
		.so(so),
		.soOe(soOe)
	);

	// ----------------------------------------
	// Derived conditions
	// ----------------------------------------
	// Received byte is stable: the serial clock stands while chip select is high
	assign cmdByte = hbsc_ctrl_t'(rxByte);
	assign pin = r.syncB.pins;
	assign frameEnd = r.syncB.csn && !r.csnLast;
	assign pinsNow = {pin.disablePin, pin.modulationPin, pin.directionPin};
	assign pinChange = pinsNow != r.pinsLast;

	assign effEn = r.ctrl.serialControlSelect ? r.ctrl.serialOutputEnable : !pin.disablePin;
	assign effDir = r.ctrl.serialControlSelect ? r.ctrl.serialDirection : pin.directionPin;
	assign effMod = r.ctrl.serialControlSelect ? r.ctrl.serialModulation : pin.modulationPin;

	assign dirChange = effDir != r.dirLast;
	assign modFall = r.modLast && !effMod;

	assign isWrite = frameEnd && (cmdByte.cmd == `HBSC_CMD_WRITE_CONTROL
		|| cmdByte.cmd == `HBSC_CMD_WRITE_CONTROL_READ_FAULT);
	assign isClear = frameEnd && cmdByte.cmd == `HBSC_CMD_CLEAR_FAULT;

	// Undervoltage, sleep and sleep exit clear latches
	assign faultClear = isClear || pin.undervoltage || pin.sleep
		|| (r.sleepLast && !pin.sleep) || (effEn && !r.enLast);

	// Short latches, one gate per output
	hbsc_short_side uSideA (
		.groundLatched(r.shorts.groundShortOutA),
		.batteryLatched(r.shorts.batteryShortOutA),
		.clear(faultClear),
		.groundNow(pin.groundShortOutA),
		.batteryNow(pin.batteryShortOutA),
		.groundSet(setGroundA),
		.batterySet(setBatteryA)
	);

	hbsc_short_side uSideB (
		.groundLatched(r.shorts.groundShortOutB),
		.batteryLatched(r.shorts.batteryShortOutB),
		.clear(faultClear),
		.groundNow(pin.groundShortOutB),
		.batteryNow(pin.batteryShortOutB),
		.groundSet(setGroundB),
		.batterySet(setBatteryB)
	);

	assign shortSet = {setBatteryB, setGroundB, setBatteryA, setGroundA};

	// Open load hidden when source is off
	assign olReport = !r.ctrl.openLoadSourceOff
		&& (r.olOn || (!effEn && pin.openLoadOff));

	// ----------------------------------------
	// Fault register view
	// ----------------------------------------
	always_comb begin
		fault.outputsEnabled = !pin.disablePin;
		fault.overtempFlagN = !pin.overtemp;
		fault.currentLimitFlagN = !r.clLatched;
		fault.transferCheckBit = 1'b0;
		if (pin.undervoltage) begin
			fault.faultCode = `HBSC_CODE_UNDERVOLTAGE;
		end else if (|r.shorts) begin
			fault.faultCode = ~r.shorts;
		end else if (olReport) begin
			fault.faultCode = `HBSC_CODE_OPEN_LOAD;
		end else begin
			fault.faultCode = `HBSC_CODE_NO_FAULT;
		end
	end

	// Latched shorts, overtemperature and undervoltage all force the bridge off
	assign stop = !effEn || (|r.shorts) || pin.overtemp || pin.undervoltage;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = r;
		n.syncA = {pins, csn};
		n.syncB = r.syncA;
		n.csnLast = r.syncB.csn;
		n.pinsLast = pinsNow;
		n.dirLast = effDir;
		n.modLast = effMod;
		n.enLast = effEn;
		n.sleepLast = pin.sleep;

		// Set wins over clear for the short and current limit latches
		n.shorts = (r.shorts & ~{$bits(r.shorts){faultClear}}) | shortSet;
		n.clLatched = (r.clLatched && !(faultClear || dirChange)) || pin.currentLimit;

		n.fwSeen = modFall ? 1'b0 : (r.fwSeen || pin.freewheel);
		if (dirChange || faultClear) begin
			n.olMiss = '0;
			n.fwGood = '0;
			// Direction change clears open load in on state
			n.olOn = 1'b0;
		end else if (modFall && effEn) begin
			if (r.fwSeen) begin
				n.olMiss = '0;
				n.fwGood = (r.fwGood < OL_LIMIT) ? r.fwGood + 3'h1 : r.fwGood;
				if (n.fwGood >= OL_LIMIT) begin
					n.olOn = 1'b0;
				end
			end else begin
				n.fwGood = '0;
				n.olMiss = (r.olMiss < OL_LIMIT) ? r.olMiss + 3'h1 : r.olMiss;
				if (n.olMiss >= OL_LIMIT) begin
					n.olOn = 1'b1;
				end
			end
		end

		if (isWrite) begin
			n.ctrl = cmdByte;
			// Select only with all three pins low
			n.ctrl.serialControlSelect = cmdByte.serialControlSelect
				&& pinsNow == 3'h0 && !pinChange;
		end else if (frameEnd && cmdByte.cmd == `HBSC_CMD_READ_CONTROL) begin
			n.ctrl.cmd = cmdByte.cmd;
		end
		// Pin change returns control to the pins
		if (pinChange) begin
			n.ctrl.serialControlSelect = 1'b0;
		end

		// Answer is held for the next frame
		n.rspLoad = frameEnd;
		if (frameEnd) begin
			case (cmdByte.cmd)
				`HBSC_CMD_READ_REVISION: begin
					n.rspSel = HBSC_RSP_REVISION;
				end
				`HBSC_CMD_READ_CONTROL,
				`HBSC_CMD_WRITE_CONTROL: begin
					n.rspSel = HBSC_RSP_CONTROL;
				end
				default: begin
					n.rspSel = HBSC_RSP_FAULT;
				end
			endcase
		end
		// Response taken one cycle late so it shows the command's own effect
		if (r.rspLoad) begin
			case (r.rspSel)
				HBSC_RSP_REVISION: begin
					n.resp = REV_BYTE;
				end
				HBSC_RSP_CONTROL: begin
					n.resp = r.ctrl;
				end
				default: begin
					n.resp = fault;
				end
			endcase
		end

		n.bridge = '0;
		if (!stop) begin
			n.bridge.outAHigh = effDir;
			n.bridge.outBHigh = !effDir;
			n.bridge.outALow = effMod && !effDir;
			n.bridge.outBLow = effMod && effDir;
		end
		// Source only in off state and when not disconnected
		n.openLoadSourceOn = !effEn && !r.ctrl.openLoadSourceOff;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			r <= '0;
			r.syncA.csn <= 1'b1;
			r.syncB.csn <= 1'b1;
			r.csnLast <= 1'b1;
			// Disable pin idles high, so release shows no false enable or pin edge
			r.syncA.pins.disablePin <= 1'b1;
			r.syncB.pins.disablePin <= 1'b1;
			r.pinsLast <= `HBSC_PINS_IDLE;
			r.rspSel <= HBSC_RSP_REVISION;
			r.ctrl <= `HBSC_CONTROL_RESET;
			r.resp <= REV_BYTE;
		end else begin
			r <= n;
		end
	end

	assign bridge = r.bridge;
	assign openLoadSourceOn = r.openLoadSourceOn;
endmodule : hbsc_top

// *** include/hbsc_consts.svh ***
`ifndef HBSC_CONSTS_SVH
`define HBSC_CONSTS_SVH

// ----------------------------------------
// Command codes, upper three bits of a byte
// ----------------------------------------
`define HBSC_CMD_READ_FAULT 3'h0
`define HBSC_CMD_READ_REVISION 3'h1
`define HBSC_CMD_READ_CONTROL 3'h3
`define HBSC_CMD_CLEAR_FAULT 3'h4
`define HBSC_CMD_WRITE_CONTROL_READ_FAULT 3'h6
`define HBSC_CMD_WRITE_CONTROL 3'h7

// ----------------------------------------
// Reset values and fixed fields
// ----------------------------------------
`define HBSC_CONTROL_RESET 8'h00
`define HBSC_FAULT_RESET 8'hdf
`define HBSC_REVISION_HIGH 4'h2
`define HBSC_CODE_NO_FAULT 4'hf
`define HBSC_CODE_OPEN_LOAD 4'hc
`define HBSC_CODE_UNDERVOLTAGE 4'h3
`define HBSC_OPEN_LOAD_PULSES 5
`define HBSC_PINS_IDLE 3'h4

`endif

// *** include/hbsc_pkg.sv ***
package hbsc_pkg;

	// ----------------------------------------
	// Register layouts
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] cmd;
		logic openLoadSourceOff;
		logic serialControlSelect;
		logic serialOutputEnable;
		logic serialDirection;
		logic serialModulation;
	} hbsc_ctrl_t;

	typedef struct packed {
		logic outputsEnabled;
		logic overtempFlagN;
		logic transferCheckBit;
		logic currentLimitFlagN;
		logic [3:0] faultCode;
	} hbsc_fault_t;

	// ----------------------------------------
	// Pins and bridge drive
	// ----------------------------------------
	typedef struct packed {
		logic disablePin;
		logic modulationPin;
		logic directionPin;
		logic overtemp;
		logic currentLimit;
		logic groundShortOutA;
		logic batteryShortOutA;
		logic groundShortOutB;
		logic batteryShortOutB;
		logic openLoadOff;
		logic freewheel;
		logic undervoltage;
		logic sleep;
	} hbsc_pins_t;

	typedef struct packed {
		logic outAHigh;
		logic outALow;
		logic outBHigh;
		logic outBLow;
	} hbsc_bridge_t;

	// Latched shorts, ordered so that inverting gives the fault code
	typedef struct packed {
		logic batteryShortOutB;
		logic groundShortOutB;
		logic batteryShortOutA;
		logic groundShortOutA;
	} hbsc_shorts_t;

	typedef enum logic [2:0] {
		HBSC_RSP_REVISION = 3'b001,
		HBSC_RSP_FAULT = 3'b010,
		HBSC_RSP_CONTROL = 3'b100
	} hbsc_rsp_t;

	typedef struct packed {
		hbsc_pins_t pins;
		logic csn;
	} hbsc_sync_t;

	// ----------------------------------------
	// Module state
	// ----------------------------------------
	typedef struct packed {
		hbsc_sync_t syncA;
		hbsc_sync_t syncB;
		logic csnLast;
		logic [2:0] pinsLast;
		logic dirLast;
		logic modLast;
		logic enLast;
		logic sleepLast;
		hbsc_ctrl_t ctrl;
		logic rspLoad;
		hbsc_rsp_t rspSel;
		logic [7:0] resp;
		hbsc_shorts_t shorts;
		logic clLatched;
		logic [2:0] olMiss;
		logic [2:0] fwGood;
		logic fwSeen;
		logic olOn;
		hbsc_bridge_t bridge;
		logic openLoadSourceOn;
	} hbsc_core_t;

	typedef struct packed {
		logic [2:0] idx;
		logic bitOut;
	} hbsc_tx_t;

endpackage : hbsc_pkg

// *** sim/hbsc_top_chk.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Port checker for the command interpreter
// ----------------------------------------
module hbsc_top_chk
	import hbsc_pkg::*;
#(
	parameter int OL_PULSES = 5,
	parameter logic [3:0] REVISION = 4'h1
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic csn,
	input wire logic si,
	input wire logic so,
	input wire logic soOe,
	input wire hbsc_pins_t pins,
	input wire hbsc_bridge_t bridge,
	input wire logic openLoadSourceOn
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// Serial side, sampled by the core clock
	// ----------------------------------------
	property p_oe_frame;
		soOe == !csn;
	endproperty
	a_oe_frame: assert property (p_oe_frame) else $error("so enable not tied to frame");

	property p_so_idle;
		csn |-> !so;
	endproperty
	a_so_idle: assert property (p_so_idle) else $error("so not low between frames");

	// Sclk edges can meet core edges in the bench; sampled values still keep this exact
	property p_so_rise;
		!csn && !$past(csn) && !$rose(sclk) |-> $stable(so);
	endproperty
	a_so_rise: assert property (p_so_rise) else $error("so moved off a rising sclk");

	// ----------------------------------------
	// Bridge drive against the pins
	// ----------------------------------------
	property p_dis_off;
		pins.disablePin [*5] |-> bridge == '0;
	endproperty
	a_dis_off: assert property (p_dis_off) else $error("bridge on while disabled");

	property p_ot_off;
		pins.overtemp [*5] |-> bridge == '0;
	endproperty
	a_ot_off: assert property (p_ot_off) else $error("bridge on in overtemperature");

	property p_uv_off;
		pins.undervoltage [*5] |-> bridge == '0;
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("bridge on in undervoltage");

	// Faults may only switch legs off, never on the wrong side
	property p_fwd;
		(!pins.disablePin && pins.modulationPin && pins.directionPin) [*5]
			|-> !bridge.outALow && !bridge.outBHigh;
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward drive wrong");

	property p_rev;
		(!pins.disablePin && pins.modulationPin && !pins.directionPin) [*5]
			|-> !bridge.outAHigh && !bridge.outBLow;
	endproperty
	a_rev: assert property (p_rev) else $error("reverse drive wrong");

	c_frame: cover property ($fell(csn));
	c_fwd: cover property (bridge == 4'h9);
	c_src: cover property ($rose(openLoadSourceOn));
endmodule : hbsc_top_chk

// *** sim/hbsc_spi_master.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Serial master model
// ----------------------------------------
module hbsc_spi_master (
	output logic sclk,
	output logic csn,
	output logic si,
	input wire logic so,
	input wire logic soOe
);
	initial begin
		sclk = 1'b0;
		si = 1'b0;
		// A clean rising chip select resets the link before the first frame
		#1;
		csn = 1'b1;
	end

	// eight bits MSB first per low
	task automatic xfer(input logic [7:0] cmd, output logic [7:0] rsp);
		csn = 1'b0;
		#62.5;
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b1;
			si = cmd[i];
			#62.5;
			sclk = 1'b0;
			rsp[i] = soOe ? so : 1'bx;
			#62.5;
		end
		csn = 1'b1;
		// Released line flips so a stale bit is never mistaken for data
		si = ~si;
		#200;
	endtask : xfer
endmodule : hbsc_spi_master

// *** sim/tb.sv ***
`timescale 1ns/1ps

module tb
	import hbsc_pkg::*;
;
	logic ref_clk;
	logic rst_b;
	logic sclk, csn, si, so, soOe, openLoadSourceOn;
	hbsc_pins_t pins;
	hbsc_bridge_t bridge;
	int errTotal;
	int checksDone;

	hbsc_top #(.OL_PULSES(5), .REVISION(4'h5)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
		.sclk(sclk), .csn(csn), .si(si), .so(so), .soOe(soOe), .pins(pins),
		.bridge(bridge), .openLoadSourceOn(openLoadSourceOn));
	hbsc_spi_master mst (.sclk(sclk), .csn(csn), .si(si), .so(so), .soOe(soOe));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic giveVerdict;
		if (errTotal == 0 && checksDone > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : giveVerdict

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checksDone++;
		if (g !== e) begin
			errTotal++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// Sends a command and checks the answer to the one before it
	task automatic tx(input logic [7:0] c, input logic [7:0] e);
		logic [7:0] r;
		#1;
		mst.xfer(c, r);
		chk(r, e);
	endtask : tx

	task automatic wt;
		repeat (10) @(posedge ref_clk);
	endtask : wt

	task automatic pulse;
		@(posedge ref_clk) pins.modulationPin <= 1'b1;
		wt;
		@(posedge ref_clk) pins.modulationPin <= 1'b0;
		wt;
	endtask : pulse

	initial begin
		repeat (60000) @(posedge ref_clk);
		errTotal++;
		giveVerdict;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		pins = '0;
		pins.disablePin = 1'b1;
		errTotal = 0;
		checksDone = 0;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		wt;
		tx(8'h60, 8'h25);
		tx(8'h20, 8'h60);
		tx(8'h00, 8'h25);
		tx(8'ha0, 8'h5f);
		tx(8'h40, 8'h5f);
		chk({7'h00, openLoadSourceOn}, 8'h01);
		tx(8'hf0, 8'h5f);
		chk({7'h00, openLoadSourceOn}, 8'h00);
		@(posedge ref_clk) pins.openLoadOff <= 1'b1;
		wt;
		tx(8'hd0, 8'hf0);
		tx(8'he0, 8'h5f);
		tx(8'h00, 8'he0);
		@(posedge ref_clk) pins.openLoadOff <= 1'b0;
		wt;
		tx(8'h00, 8'h5c);
		tx(8'h00, 8'h5f);
		@(posedge ref_clk) pins.disablePin <= 1'b0;
		wt;
		chk({4'h0, bridge}, 8'h02);
		@(posedge ref_clk) {pins.modulationPin, pins.directionPin} <= 2'b11;
		wt;
		chk({4'h0, bridge}, 8'h09);
		@(posedge ref_clk) pins.directionPin <= 1'b0;
		wt;
		chk({4'h0, bridge}, 8'h06);
		@(posedge ref_clk) pins.groundShortOutA <= 1'b1;
		wt;
		@(posedge ref_clk) pins.groundShortOutA <= 1'b0;
		wt;
		chk({4'h0, bridge}, 8'h00);
		tx(8'h00, 8'h5f);
		tx(8'h80, 8'hde);
		chk({4'h0, bridge}, 8'h06);
		tx(8'h00, 8'hdf);
		@(posedge ref_clk) pins.batteryShortOutB <= 1'b1;
		wt;
		@(posedge ref_clk) pins.batteryShortOutB <= 1'b0;
		wt;
		tx(8'h00, 8'hdf);
		@(posedge ref_clk) pins.disablePin <= 1'b1;
		wt;
		@(posedge ref_clk) pins.disablePin <= 1'b0;
		wt;
		tx(8'h00, 8'hd7);
		tx(8'h00, 8'hdf);
		@(posedge ref_clk) pins.currentLimit <= 1'b1;
		wt;
		@(posedge ref_clk) pins.currentLimit <= 1'b0;
		wt;
		tx(8'h00, 8'hdf);
		@(posedge ref_clk) pins.directionPin <= 1'b1;
		wt;
		tx(8'h00, 8'hcf);
		tx(8'h00, 8'hdf);
		@(posedge ref_clk) pins.overtemp <= 1'b1;
		wt;
		tx(8'h00, 8'hdf);
		@(posedge ref_clk) pins.overtemp <= 1'b0;
		wt;
		tx(8'h00, 8'h9f);
		@(posedge ref_clk) pins.undervoltage <= 1'b1;
		wt;
		tx(8'h00, 8'hdf);
		@(posedge ref_clk) pins.undervoltage <= 1'b0;
		wt;
		tx(8'hef, 8'hd3);
		tx(8'h60, 8'he7);
		@(posedge ref_clk) {pins.modulationPin, pins.directionPin} <= 2'b00;
		wt;
		tx(8'hef, 8'h67);
		chk({4'h0, bridge}, 8'h09);
		tx(8'hed, 8'hef);
		chk({4'h0, bridge}, 8'h06);
		tx(8'he9, 8'hed);
		chk({4'h0, bridge}, 8'h00);
		tx(8'hed, 8'he9);
		@(posedge ref_clk) pins.directionPin <= 1'b1;
		wt;
		chk({4'h0, bridge}, 8'h08);
		tx(8'h60, 8'hed);
		tx(8'h00, 8'h65);
		repeat (4) pulse;
		tx(8'h00, 8'hdf);
		pulse;
		tx(8'h00, 8'hdf);
		tx(8'h00, 8'hdc);
		@(posedge ref_clk) pins.freewheel <= 1'b1;
		repeat (4) pulse;
		tx(8'h00, 8'hdc);
		pulse;
		tx(8'h00, 8'hdc);
		tx(8'h00, 8'hdf);
		@(posedge ref_clk) pins.groundShortOutB <= 1'b1;
		wt;
		@(posedge ref_clk) pins.groundShortOutB <= 1'b0;
		wt;
		tx(8'h00, 8'hdf);
		@(posedge ref_clk) pins.sleep <= 1'b1;
		wt;
		@(posedge ref_clk) pins.sleep <= 1'b0;
		wt;
		tx(8'h00, 8'hdb);
		tx(8'h00, 8'hdf);
		giveVerdict;
	end
endmodule : tb

bind hbsc_top hbsc_top_chk #(.OL_PULSES(OL_PULSES), .REVISION(REVISION)) chk (
	.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .csn(csn), .si(si), .so(so),
	.soOe(soOe), .pins(pins), .bridge(bridge), .openLoadSourceOn(openLoadSourceOn));
